// ==== logic/dulc_host.sv ====
// Host end: Wishbone register slave driving the serial link and control pins
module dulc_host
    import dulc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link to the DAC
    dulc_if.host link
);
    import dulc_pkg::*;

    typedef enum logic [2:0] {DULC_IDLE, DULC_SHIFT, DULC_TAIL, DULC_GAP, DULC_HWRST,
        DULC_LOAD} dulc_state_t;

    dulc_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic [23:0] frame_r, frame_nxt;
    logic sclk_r, sclk_nxt, sdi_r, sdi_nxt, sync_n_r, sync_n_nxt;
    logic strobe_n_r, strobe_n_nxt, reset_n_r, reset_n_nxt;
    logic hold_low_r, hold_low_nxt, level_r, level_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic req, idle;

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign idle = (state_r == DULC_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : 16'h0000;
        bit_nxt = bit_r;
        frame_nxt = frame_r;
        sclk_nxt = sclk_r;
        sdi_nxt = sdi_r;
        sync_n_nxt = sync_n_r;
        reset_n_nxt = reset_n_r;
        hold_low_nxt = hold_low_r;
        level_nxt = level_r;
        ack_nxt = req;
        dat_nxt = dat_r;
        // ****************
        // Register access
        // ****************
        if (req) begin
            dat_nxt = 32'h00000000;
            if (wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == ADDR_CTRL) begin
                    hold_low_nxt = wb_dat_i[CTRL_HOLD_LOW];
                    level_nxt = wb_dat_i[CTRL_LEVEL_SEL];
                end
            end else if (!wb_we_i) begin
                if (wb_adr_i == ADDR_CTRL) begin
                    dat_nxt[CTRL_HOLD_LOW] = hold_low_r;
                    dat_nxt[CTRL_LEVEL_SEL] = level_r;
                end else if (wb_adr_i == ADDR_STATUS) begin
                    dat_nxt[STATUS_BUSY] = !idle;
                end
            end
        end
        // ****************
        // Link sequencing
        // ****************
        // Orders written while busy are dropped; software polls busy first
        unique case (state_r)
            DULC_IDLE: begin
                if (req && wb_we_i && wb_sel_i == 4'hF && wb_adr_i == ADDR_FRAME) begin
                    frame_nxt = wb_dat_i[23:0];
                    sdi_nxt = wb_dat_i[23];
                    sync_n_nxt = 1'b0;
                    bit_nxt = 5'h00;
                    cnt_nxt = 16'(SCLK_HALF_CYCLES);
                    state_nxt = DULC_SHIFT;
                end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL) begin
                    if (wb_dat_i[CTRL_HW_RESET]) begin
                        reset_n_nxt = 1'b0;
                        cnt_nxt = 16'(RESET_CYCLES);
                        state_nxt = DULC_HWRST;
                    end else if (wb_dat_i[CTRL_LOAD_PULSE]) begin
                        cnt_nxt = 16'(LOAD_CYCLES);
                        state_nxt = DULC_LOAD;
                    end
                end
            end
            DULC_SHIFT: begin
                if (cnt_r == 16'h0001) begin
                    cnt_nxt = 16'(SCLK_HALF_CYCLES);
                    sclk_nxt = !sclk_r;
                    if (!sclk_r) begin
                        // Data moves on the rising edge, the DAC samples on falling
                        if (bit_r != 5'h00) begin
                            frame_nxt = {frame_r[22:0], 1'b0};
                            sdi_nxt = frame_r[22];
                        end
                    end else begin
                        bit_nxt = bit_r + 5'h01;
                        if (bit_r == 5'(FRAME_BITS - 1)) begin
                            state_nxt = DULC_TAIL;
                        end
                    end
                end
            end
            DULC_TAIL: begin
                if (cnt_r == 16'h0001) begin
                    sync_n_nxt = 1'b1;
                    cnt_nxt = 16'(SYNC_GAP_CYCLES);
                    state_nxt = DULC_GAP;
                end
            end
            DULC_GAP: begin
                // Keeps any strobe pulse clear of the frame edge
                if (cnt_r == 16'h0001) begin
                    state_nxt = DULC_IDLE;
                end
            end
            DULC_HWRST: begin
                if (cnt_r == 16'h0001) begin
                    reset_n_nxt = 1'b1;
                    state_nxt = DULC_IDLE;
                end
            end
            DULC_LOAD: begin
                if (cnt_r == 16'h0001) begin
                    state_nxt = DULC_IDLE;
                end
            end
        endcase
        strobe_n_nxt = !(hold_low_nxt || state_nxt == DULC_LOAD);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= DULC_IDLE;
            cnt_r <= 16'h0000;
            bit_r <= 5'h00;
            frame_r <= 24'h000000;
            sclk_r <= 1'b0;
            sdi_r <= 1'b0;
            sync_n_r <= 1'b1;
            strobe_n_r <= 1'b1;
            reset_n_r <= 1'b1;
            hold_low_r <= 1'b0;
            level_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            frame_r <= frame_nxt;
            sclk_r <= sclk_nxt;
            sdi_r <= sdi_nxt;
            sync_n_r <= sync_n_nxt;
            strobe_n_r <= strobe_n_nxt;
            reset_n_r <= reset_n_nxt;
            hold_low_r <= hold_low_nxt;
            level_r <= level_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign link.sclk = sclk_r;
    assign link.sdi = sdi_r;
    assign link.sync_n = sync_n_r;
    assign link.load_strobe_n = strobe_n_r;
    assign link.reset_n = reset_n_r;
    assign link.reset_level_select = level_r;
endmodule

// ==== common/dulc_pkg.sv ====
// Shared constants and helpers for the DAC update and load control block
package dulc_pkg;
    // ****************
    // Frame layout
    // ****************
    localparam int FRAME_BITS = 24;
    localparam int CH_NUM = 8;
    localparam int DATA_BITS = 16;
    localparam int MASK_BITS = 4;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int CH_MSB = 18;
    localparam int CH_LSB = 16;
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_MASK = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
    // ****************
    // Reset values
    // ****************
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // ****************
    // Timing
    // ****************
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_TIME_NS = 500;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_MIN_NS = 2000;
    localparam int RESET_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_PULSE_NS = 80;
    localparam int LOAD_CYCLES = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYCLES = 4;
    localparam int SYNC_GAP_CYCLES = 8;
    // ****************
    // Controller registers
    // ****************
    localparam logic [7:0] ADDR_FRAME = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_HOLD_LOW = 0;
    localparam int CTRL_LEVEL_SEL = 1;
    localparam int CTRL_HW_RESET = 2;
    localparam int CTRL_LOAD_PULSE = 3;
    localparam int STATUS_BUSY = 0;

    function automatic logic [15:0] dulc_clear_code(input logic level_sel);
        dulc_clear_code = level_sel ? MID_CODE : ZERO_CODE;
    endfunction
endpackage

// ==== common/dulc_if.sv ====
// Serial link and control pins between the host controller and the DAC logic
interface dulc_if;
    logic sclk;
    logic sdi;
    logic sync_n;
    logic load_strobe_n;
    logic reset_n;
    logic reset_level_select;
    modport host (
        output sclk,
        output sdi,
        output sync_n,
        output load_strobe_n,
        output reset_n,
        output reset_level_select
    );
    modport device (
        input sclk,
        input sdi,
        input sync_n,
        input load_strobe_n,
        input reset_n,
        input reset_level_select
    );
endinterface

// ==== logic/dulc_shift.sv ====
// Frame assembler: shifts serial bits and flags a whole frame on sync release
module dulc_shift
    import dulc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Synchronised link levels
    input wire logic sclk_lvl,
    input wire logic sdi_lvl,
    input wire logic sync_n_lvl,
    // Frame out
    output logic frame_valid,
    output logic [23:0] frame_word
);
    logic sclk_prev_r, sclk_prev_nxt;
    logic sync_prev_r, sync_prev_nxt;
    logic [4:0] count_r, count_nxt;
    logic [23:0] word_r, word_nxt;
    logic valid_r, valid_nxt;

    always_comb begin
        sclk_prev_nxt = sclk_lvl;
        sync_prev_nxt = sync_n_lvl;
        word_nxt = word_r;
        count_nxt = count_r;
        valid_nxt = 1'b0;
        // Bits are taken on the falling clock edge while sync is low
        if (!sync_n_lvl && sclk_prev_r && !sclk_lvl) begin
            word_nxt = {word_r[22:0], sdi_lvl};
            if (count_r != 5'(FRAME_BITS)) begin
                count_nxt = count_r + 5'h01;
            end
        end
        // Short frames are dropped; longer ones keep the last 24 bits
        if (!sync_prev_r && sync_n_lvl) begin
            valid_nxt = (count_r == 5'(FRAME_BITS));
            count_nxt = 5'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_prev_r <= 1'b0;
            sync_prev_r <= 1'b1;
            count_r <= 5'h00;
            word_r <= 24'h000000;
            valid_r <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_prev_nxt;
            sync_prev_r <= sync_prev_nxt;
            count_r <= count_nxt;
            word_r <= word_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign frame_valid = valid_r;
    assign frame_word = word_r;
endmodule

// ==== logic/dulc_device.sv ====
// DAC end: frame decode, input and DAC registers, load strobe mask and resets
//
// Operation
// - Deferred mode: strobe falls after frame, updates unmasked
// - Command 0101 loads mask from DB3..DB0
// - Mask bit 1 blocks strobe for its channel pair
// - Mask 1111 makes strobe falling edges load no channel
// - 0001 writes input; DAC too if strobe low
// - 0010 copies input register into DAC register
// - 0011 writes input and DAC registers together
// - Strobe falling edge loads unmasked DAC registers
// - Strobe held low ignores mask bits
// - Hardware reset clears to zero or midscale
// - Host holds hardware reset low 2 us
// - No updates during reset; cleared value holds
// - Command 0110 restores power-on reset code
// - Power-on reset ignores strobe and reset pins
// - Power-up level follows reset level select pin
// - 24-bit frame taken at sync rising edge
// - Host supplies clock, data and frame sync
// - Strobe low 0001 updates both at sync rise
// - Top nibble DB23..DB20 is the command
module dulc_device
    import dulc_pkg::*;
#(
    parameter int POR_LEN = dulc_pkg::POR_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link from the host
    dulc_if.device link,
    // Converter codes
    output logic [dulc_pkg::CH_NUM-1:0][dulc_pkg::DATA_BITS-1:0] dac_code,
    output logic por_busy
);
    import dulc_pkg::*;

    // The power-on counter is 16 bits wide, and zero would skip the clear
    if (POR_LEN < 1 || POR_LEN > 65535) begin : g_por_len_check
        $error("POR_LEN out of range");
    end

    // ****************
    // Pin synchronisers
    // ****************
    // Order: sclk, sdi, sync_n, strobe, reset, level select
    logic [5:0] pins;
    logic [5:0] meta_r, meta_nxt;
    logic [5:0] sync_r, sync_nxt;
    logic [5:0] last_r, last_nxt;

    assign pins = {link.sclk, link.sdi, link.sync_n, link.load_strobe_n, link.reset_n,
        link.reset_level_select};

    always_comb begin
        meta_nxt = pins;
        sync_nxt = meta_r;
        last_nxt = sync_r;
    end

    // Reset values match the idle pin levels except sdi, so no false edge follows reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= 6'h1E;
            sync_r <= 6'h1E;
            last_r <= 6'h1E;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
        end
    end

    logic sclk_lvl, sdi_lvl, sync_n_lvl, strobe_lvl, hw_reset_lvl, level_sel_lvl;
    logic strobe_fall;

    assign sclk_lvl = sync_r[5];
    assign sdi_lvl = sync_r[4];
    assign sync_n_lvl = sync_r[3];
    assign strobe_lvl = sync_r[2];
    assign hw_reset_lvl = sync_r[1];
    assign level_sel_lvl = sync_r[0];
    // Edge found on synchronised levels; a pulse under one cycle may be lost
    assign strobe_fall = last_r[2] && !strobe_lvl;

    // ****************
    // Frame assembly
    // ****************
    logic frame_valid;
    logic [23:0] frame_word;

    // Same synchroniser delay on every link pin keeps data and sync aligned
    dulc_shift u_shift (
        .clock(clock),
        .rst_n(rst_n),
        .sclk_lvl(sclk_lvl),
        .sdi_lvl(sdi_lvl),
        .sync_n_lvl(sync_n_lvl),
        .frame_valid(frame_valid),
        .frame_word(frame_word)
    );

    // ****************
    // Channel registers
    // ****************
    logic [CH_NUM-1:0][DATA_BITS-1:0] input_r, input_nxt;
    logic [CH_NUM-1:0][DATA_BITS-1:0] dac_r, dac_nxt;
    logic [MASK_BITS-1:0] mask_r, mask_nxt;
    logic [15:0] por_cnt_r, por_cnt_nxt;
    logic por_busy_r, por_busy_nxt;
    logic [3:0] cmd;
    logic [2:0] ch;
    logic [15:0] data;
    logic [15:0] clear_code;

    assign cmd = frame_word[CMD_MSB:CMD_LSB];
    assign ch = frame_word[CH_MSB:CH_LSB];
    assign data = frame_word[DATA_BITS-1:0];
    // Follows the select pin live, so a change during a clear shows at once
    assign clear_code = dulc_clear_code(level_sel_lvl);

    // Two channels share one mask bit
    function automatic logic ch_masked(input logic [MASK_BITS-1:0] mask, input int idx);
        ch_masked = mask[idx / 2];
    endfunction

    always_comb begin
        input_nxt = input_r;
        dac_nxt = dac_r;
        mask_nxt = mask_r;
        por_cnt_nxt = (por_cnt_r != 16'h0000) ? por_cnt_r - 16'h0001 : 16'h0000;
        // Busy drops in the same cycle as the last power-on clear
        por_busy_nxt = (por_cnt_nxt != 16'h0000);
        if (por_cnt_r != 16'h0000) begin
            // Strobe, reset pin and frames have no effect until this ends
            for (int i = 0; i < CH_NUM; i++) begin
                input_nxt[i] = clear_code;
                dac_nxt[i] = clear_code;
            end
        end else if (!hw_reset_lvl) begin
            // Held cleared for as long as the pin stays low
            for (int i = 0; i < CH_NUM; i++) begin
                input_nxt[i] = clear_code;
                dac_nxt[i] = clear_code;
            end
        end else begin
            if (strobe_fall) begin
                for (int i = 0; i < CH_NUM; i++) begin
                    if (!ch_masked(mask_r, i)) begin
                        dac_nxt[i] = input_r[i];
                    end
                end
            end
            if (frame_valid) begin
                case (cmd)
                    CMD_WRITE_INPUT: begin
                        input_nxt[ch] = data;
                        // A low strobe makes the input register transparent
                        if (!strobe_lvl) begin
                            dac_nxt[ch] = data;
                        end
                    end
                    CMD_UPDATE: begin
                        dac_nxt[ch] = input_r[ch];
                    end
                    CMD_WRITE_UPDATE: begin
                        input_nxt[ch] = data;
                        dac_nxt[ch] = data;
                    end
                    CMD_MASK: begin
                        mask_nxt = data[MASK_BITS-1:0];
                    end
                    CMD_SOFT_RESET: begin
                        for (int i = 0; i < CH_NUM; i++) begin
                            input_nxt[i] = clear_code;
                            dac_nxt[i] = clear_code;
                        end
                        mask_nxt = MASK_RESET;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // A rst_n reset restarts the power-on count, so codes are cleared again
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            input_r <= '0;
            dac_r <= '0;
            mask_r <= MASK_RESET;
            por_cnt_r <= 16'(POR_LEN);
            por_busy_r <= 1'b1;
        end else begin
            input_r <= input_nxt;
            dac_r <= dac_nxt;
            mask_r <= mask_nxt;
            por_cnt_r <= por_cnt_nxt;
            por_busy_r <= por_busy_nxt;
        end
    end

    assign dac_code = dac_r;
    assign por_busy = por_busy_r;
endmodule

// ==== verification/dulc_properties.sv ====
// Concurrent checks on the link between the host end and the DAC end
module dulc_properties
    import dulc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link signals
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sync_n,
    input wire logic load_strobe_n,
    input wire logic reset_n,
    input wire logic reset_level_select,
    // Device outputs
    input wire logic [CH_NUM-1:0][DATA_BITS-1:0] dac_code,
    input wire logic por_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] fall_cnt_r, fall_cnt_nxt;
    logic [7:0] low_cnt_r, low_cnt_nxt;
    logic [3:0] evt_age_r, evt_age_nxt;
    logic sclk_d_r, sync_d_r, strobe_d_r;

    // ****************
    // Helper counters
    // ****************
    // Saturating or idle-cleared counts so long idle spells never wrap into false matches
    always_comb begin
        fall_cnt_nxt = sync_n ? 5'h00 : fall_cnt_r + {4'h0, sclk_d_r & ~sclk};
        low_cnt_nxt = (reset_n || low_cnt_r == 8'hFF) ? {8{~reset_n}} : low_cnt_r + 8'h01;
        evt_age_nxt = (evt_age_r == 4'hF) ? evt_age_r : evt_age_r + 4'h1;
        if ((!sync_d_r && sync_n) || (strobe_d_r && !load_strobe_n) || !reset_n) begin
            evt_age_nxt = 4'h0;
        end
    end

    always_ff @(posedge clock) begin
        fall_cnt_r <= fall_cnt_nxt;
        low_cnt_r <= low_cnt_nxt;
        evt_age_r <= evt_age_nxt;
        sclk_d_r <= sclk;
        sync_d_r <= sync_n;
        strobe_d_r <= load_strobe_n;
    end

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_sclk_idle_low: assert property (sync_n |-> !sclk)
        else $error("serial clock active outside a frame");
    a_sdi_stable_fall: assert property (!sync_n && $fell(sclk) |-> $stable(sdi))
        else $error("data changed at the sampling edge");
    a_frame_bit_count: assert property ($rose(sync_n) |-> fall_cnt_r == 5'h18)
        else $error("frame closed with a wrong bit count");
    a_sync_gap_len: assert property ($rose(sync_n) |-> sync_n [*8])
        else $error("frame gap too short");
    a_strobe_pulse_len: assert property ($fell(load_strobe_n) |-> !load_strobe_n [*8])
        else $error("load strobe pulse too short");
    a_reset_low_len: assert property ($rose(reset_n) |-> low_cnt_r >= RESET_CYCLES)
        else $error("hardware reset released too early");
    a_reset_clears: assert property ((!reset_n && !por_busy) [*8]
        |-> dac_code == {CH_NUM{reset_level_select ? MID_CODE : ZERO_CODE}})
        else $error("outputs not held at the clear code");
    a_update_has_cause: assert property ($changed(dac_code) && !por_busy && !$past(por_busy)
        |-> evt_age_r <= 4'h8)
        else $error("output changed with no frame, strobe or reset");
    a_power_up_level: assert property ($fell(por_busy)
        |-> dac_code == {CH_NUM{reset_level_select ? MID_CODE : ZERO_CODE}})
        else $error("power-up code wrong");
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench: host end driven over Wishbone, DAC end observed
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dulc_pkg::*;

    logic clock, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, por_busy, hold_m, lvl_m;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic [3:0] wb_sel, mask_m, cmd, m;
    logic [CH_NUM-1:0][DATA_BITS-1:0] dac_code;
    logic [15:0] in_m [CH_NUM];
    logic [15:0] dac_m [CH_NUM];
    int mismatches = 0;
    int tests_run = 0;
    int cyc_cnt = 0;

    dulc_if link_if();
    dulc_host u_dulc_host(.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(link_if.host));
    // Short power-on count keeps the run brief
    dulc_device #(.POR_LEN(4)) u_dulc_device(.clock(clock), .rst_n(rst_n),
        .link(link_if.device), .dac_code(dac_code), .por_busy(por_busy));
    dulc_properties u_dulc_properties(.clock(clock), .rst_n(rst_n), .sclk(link_if.sclk),
        .sdi(link_if.sdi), .sync_n(link_if.sync_n), .load_strobe_n(link_if.load_strobe_n),
        .reset_n(link_if.reset_n), .reset_level_select(link_if.reset_level_select),
        .dac_code(dac_code), .por_busy(por_busy));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ****************
    // Expectation model
    // ****************
    function automatic logic [15:0] clr(input logic l);
        return l ? MID_CODE : ZERO_CODE;
    endfunction

    function automatic void clear_model();
        for (int i = 0; i < CH_NUM; i++) begin
            in_m[i] = clr(lvl_m);
            dac_m[i] = clr(lvl_m);
        end
    endfunction

    function automatic void model_strobe();
        for (int i = 0; i < CH_NUM; i++) begin
            if (!mask_m[i / 2]) dac_m[i] = in_m[i];
        end
    endfunction

    function automatic void model_frame(input logic [3:0] c, input logic [2:0] ch,
        input logic [15:0] d);
        case (c)
            CMD_WRITE_INPUT: begin
                in_m[ch] = d;
                if (hold_m) dac_m[ch] = d;
            end
            CMD_UPDATE: dac_m[ch] = in_m[ch];
            CMD_WRITE_UPDATE: begin
                in_m[ch] = d;
                dac_m[ch] = d;
            end
            CMD_MASK: mask_m = d[3:0];
            CMD_SOFT_RESET: begin
                clear_model();
                mask_m = MASK_RESET;
            end
            default: ;
        endcase
    endfunction

    // ****************
    // Bus tasks
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= 4'hF;
        do @(posedge clock); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wait_idle();
        do wb_cycle(1'b0, ADDR_STATUS, 32'h0); while (q[STATUS_BUSY] !== 1'b0);
    endtask

    task automatic send(input logic [3:0] c, input logic [2:0] ch, input logic [15:0] d);
        wait_idle();
        wb_cycle(1'b1, ADDR_FRAME, {8'h00, c, 1'b0, ch, d});
        wait_idle();
        model_frame(c, ch, d);
    endtask

    task automatic ctrl(input logic hold, input logic lvl, input logic rst, input logic pulse);
        if (hold && !hold_m) model_strobe();
        hold_m = hold;
        lvl_m = lvl;
        wb_cycle(1'b1, ADDR_CTRL, {28'h0, pulse, rst, lvl, hold});
        wait_idle();
        if (rst) clear_model();
        else if (pulse && !hold) model_strobe();
    endtask

    task automatic check_dacs();
        for (int i = 0; i < CH_NUM; i++) check("dac_code", 32'(dac_code[i]), 32'(dac_m[i]));
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // A hang ends the run as a failure
    always @(posedge clock) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ****************
    // Tests
    // ****************
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} = '0;
        {rst_n, hold_m, lvl_m, mask_m} = '0;
        for (int i = 0; i < CH_NUM; i++) begin
            in_m[i] = 16'h0000;
            dac_m[i] = 16'h0000;
        end
        void'($urandom(32'hE31B));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        wb_cycle(1'b0, 8'h0C, 32'hFFFF_FFFF);
        check("unmapped", q, 32'h0);
        wb_cycle(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", q, 32'h0);
        while (por_busy !== 1'b0) @(posedge clock);
        check_dacs();
        $display("test power_up done");
        repeat (16) begin
            cmd = 4'($urandom_range(3, 0));
            if (cmd == 4'h0) cmd = 4'hF;
            send(cmd, 3'($urandom), 16'($urandom));
            check_dacs();
        end
        $display("test commands done");
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 4'h0 : (k == 1) ? 4'($urandom_range(14, 1)) : 4'hF;
            send(CMD_MASK, 3'($urandom), {12'hFFF, m});
            for (int ch = 0; ch < CH_NUM; ch++) send(CMD_WRITE_INPUT, 3'(ch), 16'($urandom));
            check_dacs();
            ctrl(1'b0, 1'b0, 1'b0, 1'b1);
            check_dacs();
        end
        $display("test deferred done");
        ctrl(1'b1, 1'b0, 1'b0, 1'b0);
        check_dacs();
        send(CMD_WRITE_INPUT, 3'h5, 16'($urandom));
        check_dacs();
        ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test hold_low done");
        ctrl(1'b0, 1'b1, 1'b0, 1'b0);
        ctrl(1'b0, 1'b1, 1'b1, 1'b0);
        check_dacs();
        ctrl(1'b0, 1'b1, 1'b0, 1'b1);
        ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        check_dacs();
        $display("test hw_reset done");
        send(CMD_WRITE_UPDATE, 3'h2, 16'($urandom));
        send(CMD_SOFT_RESET, 3'h0, 16'h0000);
        check_dacs();
        send(CMD_WRITE_INPUT, 3'h1, 16'($urandom));
        ctrl(1'b0, 1'b0, 1'b0, 1'b1);
        check_dacs();
        $display("test soft_reset done");
        give_verdict();
    end
endmodule
